//--- sim/cirs_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cirs_top_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic nmi_n = 1'b1, bnd = 1'b0, fv = 1'b0, fu = 1'b0, err;
  logic [7:0] paddr = 8'h00, op = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [14:0] ev = 15'h0;
  logic [15:0] cd = 16'h1111, cx = 16'h2222, cy = 16'h3333, cpc = 16'h4444, rdat;
  logic pready, pslverr, rv, vv, irq;
  logic hold, srst, ph = 1'b0;
  logic [7:0] cfw;
  logic [2:0] rsel;
  logic [4:0] vid;
  int failures = 0;
  int samples_checked = 0;
  always #5 pclk = ~pclk;
  cirs_top #(.CLK_LOSS_CYCLES(50), .WDOG_CYCLES(64)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_clk_in(ph),
    .nonmaskable_request_pin_n(nmi_n), .irq_event(ev), .insn_boundary(bnd),
    .fetch_valid(fv), .fetch_opcode(op), .fetch_undefined(fu), .flags_we(1'b0),
    .flags_wd(8'h00), .core_d(cd), .core_x(cx), .core_y(cy), .core_pc(cpc),
    .core_hold(hold), .sys_reset(srst), .condition_flags_word(cfw), .restore_valid(rv),
    .restore_sel(rsel), .restore_data(rdat), .vector_valid(vv), .vector_id(vid),
    .irq_out(irq));
  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  // Fetch cycle, then one boundary cycle
  task automatic go(input logic f, input logic [7:0] o, input logic u);
    fv <= f;
    op <= o;
    fu <= u;
    @(posedge pclk);
    fv <= 1'b0;
    fu <= 1'b0;
    bnd <= 1'b1;
    @(posedge pclk);
    bnd <= 1'b0;
  endtask
  task automatic evb(input logic [14:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 15'h0;
    go(1'b0, 8'h00, 1'b0);
  endtask
  task automatic wvec(input string nm, input logic [4:0] e);
    int n;
    logic rc;
    n = 0;
    rc = e == cirs_pkg::VEC_CLK || e == cirs_pkg::VEC_WDOG;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (vv !== 1'b1 && n < 300);
    chk(nm, {hold, srst, vv, vid}, {1'b1, rc, 1'b1, e});
    @(posedge pclk);
  endtask
  task automatic irqc(input string nm, input logic e);
    @(negedge pclk);
    chk(nm, irq, e);
    @(posedge pclk);
  endtask
  task automatic return_from_trap_opcode(input logic [15:0] f);
    logic [18:0] e [5];
    int k;
    e = '{{3'h4, cpc}, {3'h3, cy}, {3'h2, cx}, {3'h1, cd}, {3'h0, f}};
    k = 0;
    go(1'b1, cirs_pkg::RETURN_OP, 1'b0);
    repeat (10)
    begin
      @(negedge pclk);
      if (rv === 1'b1 && k < 5)
      begin
        chk("restore", {rsel, rdat}, e[k]);
        k++;
      end
    end
    chk("pops", k, 5);
    @(posedge pclk);
  endtask
  initial
  begin
    #60us;
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("flags", cirs_pkg::ADDR_FLAGS, cirs_pkg::FLAGS_RST);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    apb(1'b1, cirs_pkg::ADDR_IRQ_EN, 32'h3);
    evb(15'h1);
    repeat (8) @(posedge pclk);
    rdc("pend", cirs_pkg::ADDR_IRQ_PEND, 32'h1);
    rdc("masked", cirs_pkg::ADDR_STATE, 32'h0);
    apb(1'b1, cirs_pkg::ADDR_FLAGS, 32'h40);
    go(1'b0, 8'h00, 1'b0);
    wvec("mvec", cirs_pkg::VEC_MASK0);
    rdc("mset", cirs_pkg::ADDR_FLAGS, 32'h50);
    apb(1'b1, cirs_pkg::ADDR_IRQ_PEND, 32'h1);
    apb(1'b1, cirs_pkg::ADDR_FLAGS, 32'h40);
    evb(15'h2);
    wvec("nest", cirs_pkg::VEC_MASK0 + 5'h01);
    apb(1'b1, cirs_pkg::ADDR_IRQ_PEND, 32'h2);
    return_from_trap_opcode(16'h0040);
    return_from_trap_opcode(16'h0040);
    rdc("mback", cirs_pkg::ADDR_FLAGS, 32'h40);
    chk("cfw", cfw, 8'h40);
    apb(1'b1, cirs_pkg::ADDR_FLAGS, 32'h10);
    nmi_n <= 1'b0;
    repeat (4) @(posedge pclk);
    go(1'b1, cirs_pkg::SOFT_TRAP_OP, 1'b0);
    wvec("trap", cirs_pkg::VEC_TRAP);
    go(1'b0, 8'h00, 1'b0);
    wvec("pin", cirs_pkg::VEC_NMI);
    go(1'b0, 8'h00, 1'b0);
    rdc("xmask", cirs_pkg::ADDR_STATE, 32'h50);
    nmi_n <= 1'b1;
    irqc("irq0", 1'b0);
    apb(1'b1, cirs_pkg::ADDR_EV_MASK, 32'h8);
    irqc("irq1", 1'b1);
    apb(1'b1, cirs_pkg::ADDR_EV_STAT, 32'h8);
    irqc("irqc", 1'b0);
    go(1'b1, 8'h00, 1'b1);
    wvec("ill", cirs_pkg::VEC_ILL);
    apb(1'b1, cirs_pkg::ADDR_CTRL, 32'h1);
    // Running phase clock keeps the watch quiet
    repeat (10)
    begin
      repeat (8) @(posedge pclk);
      ph <= ~ph;
    end
    rdc("clkok", cirs_pkg::ADDR_EV_STAT, 32'h14);
    wvec("clkf", cirs_pkg::VEC_CLK);
    rdc("clkr", cirs_pkg::ADDR_FLAGS, cirs_pkg::FLAGS_RST);
    apb(1'b1, cirs_pkg::ADDR_FLAGS, 32'h40);
    apb(1'b1, cirs_pkg::ADDR_CTRL, 32'h2);
    repeat (3)
    begin
      repeat (40) @(posedge pclk);
      apb(1'b1, cirs_pkg::ADDR_KICK, cirs_pkg::WDOG_KEY);
    end
    rdc("wdok", cirs_pkg::ADDR_FLAGS, 32'h40);
    wvec("wdf", cirs_pkg::VEC_WDOG);
    rdc("wdr", cirs_pkg::ADDR_FLAGS, cirs_pkg::FLAGS_RST);
    presetn <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk("rst", {vv, vid}, {1'b1, cirs_pkg::VEC_RESET});
    end_sim();
  end
endmodule
`default_nettype wire

//--- src/cirs_pkg.sv
package cirs_pkg;

  // ****************************************
  // APB register map (byte addresses)
  // ****************************************
  localparam int AW = 8;
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_FLAGS = 8'h04;
  localparam logic [AW-1:0] ADDR_IRQ_EN = 8'h08;
  localparam logic [AW-1:0] ADDR_IRQ_PEND = 8'h0c;
  localparam logic [AW-1:0] ADDR_ELEV = 8'h10;
  localparam logic [AW-1:0] ADDR_KICK = 8'h14;
  localparam logic [AW-1:0] ADDR_EV_STAT = 8'h18;
  localparam logic [AW-1:0] ADDR_EV_MASK = 8'h1c;
  localparam logic [AW-1:0] ADDR_STATE = 8'h20;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int CTRL_CLKMON = 0;
  localparam int CTRL_WDOG = 1;
  localparam int FLAG_I = 4;
  localparam int FLAG_X = 6;
  localparam logic [7:0] FLAGS_RST = 8'h50;
  localparam logic [1:0] PINS_RST = 2'h3;
  localparam int EV_CLK = 0;
  localparam int EV_WDOG = 1;
  localparam int EV_ILL = 2;
  localparam int EV_TRAP = 3;
  localparam int EV_NMI = 4;
  localparam int EV_OVF = 5;
  localparam int EV_W = 6;
  // Opcode and key values are arbitrary
  localparam logic [7:0] SOFT_TRAP_OP = 8'hf1;
  localparam logic [7:0] RETURN_OP = 8'hf2;
  localparam logic [7:0] WDOG_KEY = 8'h5a;

  // ****************************************
  // Vectors and stack frame
  // ****************************************
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_CLK = 5'h01;
  localparam logic [4:0] VEC_WDOG = 5'h02;
  localparam logic [4:0] VEC_ILL = 5'h03;
  localparam logic [4:0] VEC_TRAP = 5'h04;
  localparam logic [4:0] VEC_NMI = 5'h05;
  localparam logic [4:0] VEC_MASK0 = 5'h06;
  localparam logic [2:0] FR_FLAGS = 3'h0;
  localparam logic [2:0] FR_D = 3'h1;
  localparam logic [2:0] FR_X = 3'h2;
  localparam logic [2:0] FR_Y = 3'h3;
  localparam logic [2:0] FR_PC = 3'h4;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_LOSS_MIN_HZ = 10000;
  localparam int CLK_LOSS_PERIOD_NS = 1000000000 / CLK_LOSS_MIN_HZ;
  localparam int CLK_LOSS_CYCLES = CLK_LOSS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int WDOG_TIMEOUT_NS = 655360;
  localparam int WDOG_CYCLES = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {S_IDLE, S_PUSH, S_VEC, S_POP, S_POPEND} cirs_state_t;

endpackage

//--- src/cirs_stack.sv
`timescale 1ns/1ps
`default_nettype none
module cirs_stack #(
  parameter int DEPTH = 384,
  parameter int LW = 9
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stack port
  cirs_stack_if.mem stk
);

  logic [15:0] mem_q [DEPTH];
  logic [LW-1:0] sp_q;
  logic [15:0] rdata_q;

  assign stk.full = (sp_q == LW'(DEPTH));
  assign stk.empty = (sp_q == '0);
  assign stk.level = sp_q;
  assign stk.rdata = rdata_q;

  // Push writes above the top, pop reads the top word
  always_ff @(posedge pclk)
  begin
    if (stk.push && !stk.full)
    begin
      mem_q[sp_q] <= stk.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_q <= '0;
      rdata_q <= '0;
    end
    else if (stk.clear)
    begin
      sp_q <= '0;
    end
    else if (stk.push && !stk.full)
    begin
      sp_q <= LW'(sp_q + 1'b1);
    end
    else if (stk.pop && !stk.empty)
    begin
      rdata_q <= mem_q[LW'(sp_q - 1'b1)];
      sp_q <= LW'(sp_q - 1'b1);
    end
  end

endmodule
`default_nettype wire

//--- src/cirs_stack_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cirs_stack_if #(parameter int LW = 9);
  logic push;
  logic pop;
  logic clear;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic full;
  logic empty;
  logic [LW-1:0] level;
  modport master (output push, pop, clear, wdata, input rdata, full, empty, level);
  modport mem (input push, pop, clear, wdata, output rdata, full, empty, level);
endinterface
`default_nettype wire

//--- src/cirs_top.sv
`timescale 1ns/1ps
`default_nettype none
module cirs_top #(
  parameter int NIRQ = 15,
  parameter int STACK_WORDS = 384,
  parameter int CLK_LOSS_CYCLES = cirs_pkg::CLK_LOSS_CYCLES,
  parameter int WDOG_CYCLES = cirs_pkg::WDOG_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic phase_clk_in,
  input wire logic nonmaskable_request_pin_n,
  // Peripheral request events
  input wire logic [NIRQ-1:0] irq_event,
  // Core fetch and boundary
  input wire logic insn_boundary,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_opcode,
  input wire logic fetch_undefined,
  // Core register values
  input wire logic flags_we,
  input wire logic [7:0] flags_wd,
  input wire logic [15:0] core_d,
  input wire logic [15:0] core_x,
  input wire logic [15:0] core_y,
  input wire logic [15:0] core_pc,
  // Core control
  output logic core_hold,
  output logic sys_reset,
  output logic [7:0] condition_flags_word,
  output logic restore_valid,
  output logic [2:0] restore_sel,
  output logic [15:0] restore_data,
  output logic vector_valid,
  output logic [4:0] vector_id,
  // Interrupt
  output logic irq_out
);

  localparam int LW = $clog2(STACK_WORDS + 1);
  localparam int CLW = $clog2(CLK_LOSS_CYCLES + 1);
  localparam int WLW = $clog2(WDOG_CYCLES + 1);

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0] pin_in, s1_q, s2_q, s3_q, filt_q;
  logic ph_prev_q;
  logic [CLW-1:0] clk_cnt_q;
  logic [WLW-1:0] wd_cnt_q;
  logic clk_fail, wd_fail, reset_evt, kick;
  logic [1:0] ctrl_q;
  logic [7:0] flags_q;
  logic [NIRQ-1:0] irq_en_q, pend_q;
  logic [3:0] elev_q;
  logic [cirs_pkg::EV_W-1:0] ev_stat_q, ev_mask_q, ev_set;
  logic ill_pend_q, trap_pend_q, ret_pend_q, nmi_svc_q;
  cirs_pkg::cirs_state_t state_q;
  logic [2:0] idx_q;
  logic [4:0] vec_id_q;
  logic rst_v_q, sys_rst_q;
  logic [2:0] rst_sel_q;
  logic [31:0] prdata_q;
  logic wr, go, nmi_act, take, take_nmi;
  logic [4:0] take_id, pick;
  logic [15:0] push_word;

  cirs_stack_if #(.LW(LW)) stk ();

  cirs_stack #(.DEPTH(STACK_WORDS), .LW(LW)) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .stk(stk)
  );

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] merge_flags(input logic [7:0] old, input logic [7:0] nw);
    // Pin-mask bit can be cleared by writes but never set
    return nw & ~(8'h01 << cirs_pkg::FLAG_X) | (nw & old & (8'h01 << cirs_pkg::FLAG_X));
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == cirs_pkg::ADDR_CTRL || a == cirs_pkg::ADDR_FLAGS
        || a == cirs_pkg::ADDR_IRQ_EN || a == cirs_pkg::ADDR_IRQ_PEND
        || a == cirs_pkg::ADDR_ELEV || a == cirs_pkg::ADDR_KICK
        || a == cirs_pkg::ADDR_EV_STAT || a == cirs_pkg::ADDR_EV_MASK
        || a == cirs_pkg::ADDR_STATE;
  endfunction

  function automatic logic [4:0] pick_irq(input logic [NIRQ-1:0] p, input logic [3:0] e);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      if (p[i])
      begin
        r = {1'b1, 4'(i)};
      end
    end
    if (int'(e) < NIRQ && p[e])
    begin
      r = {1'b1, e};
    end
    return r;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pin_in = {nonmaskable_request_pin_n, phase_clk_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= cirs_pkg::PINS_RST;
      s2_q <= cirs_pkg::PINS_RST;
      s3_q <= cirs_pkg::PINS_RST;
      filt_q <= cirs_pkg::PINS_RST;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & filt_q);
    end
  end

  // ****************************************
  // Clock-loss watch and liveness watchdog
  // ****************************************
  assign clk_fail = ctrl_q[cirs_pkg::CTRL_CLKMON]
                    && clk_cnt_q == CLW'(CLK_LOSS_CYCLES - 1);
  assign kick = wr && paddr == cirs_pkg::ADDR_KICK && pwdata[7:0] == cirs_pkg::WDOG_KEY;
  assign wd_fail = ctrl_q[cirs_pkg::CTRL_WDOG] && wd_cnt_q == WLW'(WDOG_CYCLES - 1);
  assign reset_evt = clk_fail || wd_fail;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ph_prev_q <= cirs_pkg::PINS_RST[0];
      clk_cnt_q <= '0;
    end
    else
    begin
      ph_prev_q <= filt_q[0];
      // No rising phase edge for a full 100 us period counts as loss
      if (!ctrl_q[cirs_pkg::CTRL_CLKMON] || (filt_q[0] && !ph_prev_q) || clk_fail)
      begin
        clk_cnt_q <= '0;
      end
      else
      begin
        clk_cnt_q <= CLW'(clk_cnt_q + 1'b1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wd_cnt_q <= '0;
    end
    else if (!ctrl_q[cirs_pkg::CTRL_WDOG] || kick || reset_evt)
    begin
      wd_cnt_q <= '0;
    end
    else
    begin
      wd_cnt_q <= WLW'(wd_cnt_q + 1'b1);
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (psel && !penable)
    begin
      unique case (paddr)
        cirs_pkg::ADDR_CTRL: prdata_q <= 32'(ctrl_q);
        cirs_pkg::ADDR_FLAGS: prdata_q <= 32'(flags_q);
        cirs_pkg::ADDR_IRQ_EN: prdata_q <= 32'(irq_en_q);
        cirs_pkg::ADDR_IRQ_PEND: prdata_q <= 32'(pend_q);
        cirs_pkg::ADDR_ELEV: prdata_q <= 32'(elev_q);
        cirs_pkg::ADDR_EV_STAT: prdata_q <= 32'(ev_stat_q);
        cirs_pkg::ADDR_EV_MASK: prdata_q <= 32'(ev_mask_q);
        cirs_pkg::ADDR_STATE: prdata_q <= 32'({stk.level, state_q});
        default: prdata_q <= '0;
      endcase
    end
  end

  // Control, enables, elevation and event mask; all but the event mask cleared by reset-class events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
      irq_en_q <= '0;
      elev_q <= '0;
      ev_mask_q <= '0;
    end
    else if (reset_evt)
    begin
      ctrl_q <= '0;
      irq_en_q <= '0;
      elev_q <= '0;
    end
    else if (wr)
    begin
      if (paddr == cirs_pkg::ADDR_CTRL)
      begin
        // Watchdog enable is write-once until reset
        ctrl_q <= pwdata[1:0] | (ctrl_q & (2'h1 << cirs_pkg::CTRL_WDOG));
      end
      if (paddr == cirs_pkg::ADDR_IRQ_EN)
      begin
        irq_en_q <= pwdata[NIRQ-1:0];
      end
      if (paddr == cirs_pkg::ADDR_ELEV)
      begin
        elev_q <= pwdata[3:0];
      end
      if (paddr == cirs_pkg::ADDR_EV_MASK)
      begin
        ev_mask_q <= pwdata[cirs_pkg::EV_W-1:0];
      end
    end
  end

  // Pending flags: set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= '0;
    end
    else if (reset_evt)
    begin
      pend_q <= '0;
    end
    else
    begin
      pend_q <= (pend_q & ~((wr && paddr == cirs_pkg::ADDR_IRQ_PEND) ? pwdata[NIRQ-1:0] : '0))
                | (irq_event & irq_en_q);
    end
  end

  // ****************************************
  // Event status and interrupt output
  // ****************************************
  assign ev_set[cirs_pkg::EV_CLK] = clk_fail;
  assign ev_set[cirs_pkg::EV_WDOG] = wd_fail;
  assign ev_set[cirs_pkg::EV_ILL] = fetch_valid && fetch_undefined;
  assign ev_set[cirs_pkg::EV_TRAP] = go && take && take_id == cirs_pkg::VEC_TRAP;
  assign ev_set[cirs_pkg::EV_NMI] = go && take && take_nmi;
  assign ev_set[cirs_pkg::EV_OVF] = stk.push && stk.full;
  assign irq_out = |(ev_stat_q & ev_mask_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev_stat_q <= '0;
    end
    else
    begin
      ev_stat_q <= (ev_stat_q & ~((wr && paddr == cirs_pkg::ADDR_EV_STAT)
                   ? pwdata[cirs_pkg::EV_W-1:0] : '0)) | ev_set;
    end
  end

  // ****************************************
  // Trap latches
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ill_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      ret_pend_q <= 1'b0;
    end
    else if (reset_evt)
    begin
      ill_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      ret_pend_q <= 1'b0;
    end
    else
    begin
      ill_pend_q <= (ill_pend_q && !(go && take_id == cirs_pkg::VEC_ILL && take))
                    || (fetch_valid && fetch_undefined);
      trap_pend_q <= (trap_pend_q && !(go && take_id == cirs_pkg::VEC_TRAP && take))
                     || (fetch_valid && !fetch_undefined
                         && fetch_opcode == cirs_pkg::SOFT_TRAP_OP);
      ret_pend_q <= (ret_pend_q && !(go && !take))
                    || (fetch_valid && !fetch_undefined && fetch_opcode == cirs_pkg::RETURN_OP);
    end
  end

  // ****************************************
  // Service selection
  // ****************************************
  assign go = state_q == cirs_pkg::S_IDLE && insn_boundary;
  assign nmi_act = !filt_q[1] && !flags_q[cirs_pkg::FLAG_X];
  assign pick = pick_irq(pend_q & irq_en_q, elev_q);

  always_comb
  begin
    take = 1'b1;
    take_nmi = 1'b0;
    take_id = cirs_pkg::VEC_RESET;
    // Mask bit gates only the maskable branch
    if (ill_pend_q)
    begin
      take_id = cirs_pkg::VEC_ILL;
    end
    else if (trap_pend_q)
    begin
      take_id = cirs_pkg::VEC_TRAP;
    end
    else if (nmi_act)
    begin
      take_id = cirs_pkg::VEC_NMI;
      take_nmi = 1'b1;
    end
    else if (pick[4] && !flags_q[cirs_pkg::FLAG_I])
    begin
      take_id = 5'(cirs_pkg::VEC_MASK0 + {1'b0, pick[3:0]});
    end
    else
    begin
      take = 1'b0;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= cirs_pkg::S_VEC;
      vec_id_q <= cirs_pkg::VEC_RESET;
      idx_q <= '0;
      nmi_svc_q <= 1'b0;
    end
    else if (reset_evt)
    begin
      state_q <= cirs_pkg::S_VEC;
      vec_id_q <= clk_fail ? cirs_pkg::VEC_CLK : cirs_pkg::VEC_WDOG;
      idx_q <= '0;
    end
    else
    begin
      unique case (state_q)
        cirs_pkg::S_IDLE:
        begin
          idx_q <= '0;
          if (go && take)
          begin
            state_q <= cirs_pkg::S_PUSH;
            vec_id_q <= take_id;
            nmi_svc_q <= take_nmi;
          end
          else if (go && ret_pend_q)
          begin
            state_q <= cirs_pkg::S_POP;
          end
        end
        cirs_pkg::S_PUSH:
        begin
          idx_q <= 3'(idx_q + 3'h1);
          if (idx_q == cirs_pkg::FR_PC)
          begin
            state_q <= cirs_pkg::S_VEC;
          end
        end
        cirs_pkg::S_VEC:
        begin
          state_q <= cirs_pkg::S_IDLE;
        end
        cirs_pkg::S_POP:
        begin
          idx_q <= 3'(idx_q + 3'h1);
          if (idx_q == cirs_pkg::FR_PC)
          begin
            state_q <= cirs_pkg::S_POPEND;
          end
        end
        cirs_pkg::S_POPEND:
        begin
          state_q <= cirs_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Frame words in push order
  always_comb
  begin
    unique case (idx_q)
      cirs_pkg::FR_FLAGS: push_word = {8'h00, flags_q};
      cirs_pkg::FR_D: push_word = core_d;
      cirs_pkg::FR_X: push_word = core_x;
      cirs_pkg::FR_Y: push_word = core_y;
      default: push_word = core_pc;
    endcase
  end

  assign stk.push = state_q == cirs_pkg::S_PUSH;
  assign stk.pop = state_q == cirs_pkg::S_POP;
  assign stk.clear = reset_evt;
  assign stk.wdata = push_word;

  // Pops come out in reverse frame order, data one cycle later
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_v_q <= 1'b0;
      rst_sel_q <= '0;
      sys_rst_q <= 1'b0;
    end
    else
    begin
      rst_v_q <= stk.pop && !reset_evt;
      rst_sel_q <= 3'(cirs_pkg::FR_PC - idx_q);
      sys_rst_q <= reset_evt;
    end
  end

  // Condition flags word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_q <= cirs_pkg::FLAGS_RST;
    end
    else if (reset_evt)
    begin
      flags_q <= cirs_pkg::FLAGS_RST;
    end
    else if (rst_v_q && rst_sel_q == cirs_pkg::FR_FLAGS)
    begin
      flags_q <= stk.rdata[7:0];
    end
    else if (state_q == cirs_pkg::S_PUSH && idx_q == cirs_pkg::FR_PC)
    begin
      flags_q <= flags_q | (8'h01 << cirs_pkg::FLAG_I)
                 | (nmi_svc_q ? (8'h01 << cirs_pkg::FLAG_X) : 8'h00);
    end
    else if (flags_we)
    begin
      flags_q <= merge_flags(flags_q, flags_wd);
    end
    else if (wr && paddr == cirs_pkg::ADDR_FLAGS)
    begin
      flags_q <= merge_flags(flags_q, pwdata[7:0]);
    end
  end

  assign core_hold = state_q != cirs_pkg::S_IDLE;
  assign sys_reset = sys_rst_q;
  assign condition_flags_word = flags_q;
  assign restore_valid = rst_v_q;
  assign restore_sel = rst_sel_q;
  assign restore_data = stk.rdata;
  assign vector_valid = state_q == cirs_pkg::S_VEC;
  assign vector_id = vec_id_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence push_head;
    state_q == cirs_pkg::S_PUSH && idx_q == cirs_pkg::FR_FLAGS && push_word[7:0] == flags_q;
  endsequence

  sequence push_tail;
    state_q == cirs_pkg::S_PUSH && idx_q == cirs_pkg::FR_PC && push_word == core_pc
      ##1 state_q == cirs_pkg::S_VEC;
  endsequence

  a_nmi_any_mask: assert property (go && !ill_pend_q && !trap_pend_q && nmi_act && !reset_evt
    |=> state_q == cirs_pkg::S_PUSH && vec_id_q == cirs_pkg::VEC_NMI)
    else $error("request pin not serviced");
  a_clk_fail_vec: assert property (clk_fail
    |=> state_q == cirs_pkg::S_VEC && vec_id_q == cirs_pkg::VEC_CLK && sys_reset)
    else $error("clock failure not vectored");
  a_wdog_vec: assert property (wd_fail && !clk_fail
    |=> state_q == cirs_pkg::S_VEC && vec_id_q == cirs_pkg::VEC_WDOG)
    else $error("watchdog failure not vectored");
  a_reset_clears: assert property (reset_evt
    |=> flags_q == cirs_pkg::FLAGS_RST && pend_q == '0 && ctrl_q == '0)
    else $error("reset event left state");
  a_ill_first: assert property (go && ill_pend_q && !reset_evt
    |=> vec_id_q == cirs_pkg::VEC_ILL && state_q == cirs_pkg::S_PUSH)
    else $error("illegal opcode lost priority");
  a_trap_next: assert property (go && trap_pend_q && !ill_pend_q && !reset_evt
    |=> vec_id_q == cirs_pkg::VEC_TRAP)
    else $error("soft trap not next");
  a_mask_gate: assert property (go && flags_q[cirs_pkg::FLAG_I] && !ill_pend_q && !trap_pend_q
    && !nmi_act && !ret_pend_q && !reset_evt |=> state_q == cirs_pkg::S_IDLE)
    else $error("maskable serviced while masked");
  a_stack_zero: assert property (state_q == cirs_pkg::S_PUSH && idx_q == cirs_pkg::FR_FLAGS
    && vec_id_q >= cirs_pkg::VEC_MASK0 |-> !push_word[cirs_pkg::FLAG_I])
    else $error("stacked mask bit set");
  a_push_frame: assert property (push_head |-> ##4 push_tail)
    else $error("frame order broken");
  a_mask_set: assert property (state_q == cirs_pkg::S_PUSH && idx_q == cirs_pkg::FR_PC
    && !reset_evt |=> flags_q[cirs_pkg::FLAG_I] && vector_valid)
    else $error("mask not set before vector");
  a_ret_restore: assert property (rst_v_q && rst_sel_q == cirs_pkg::FR_FLAGS && !reset_evt
    |=> flags_q == $past(stk.rdata[7:0]))
    else $error("flags not restored");
  a_boundary_only: assert property (state_q == cirs_pkg::S_IDLE && !reset_evt
    ##1 (state_q == cirs_pkg::S_PUSH || state_q == cirs_pkg::S_POP) |-> $past(insn_boundary))
    else $error("service began mid instruction");

endmodule
`default_nettype wire
